// >>> verilog/seeprom_engine.v
// two-wire slave engine of a serial eeprom with a read-only serial number region
`timescale 1ns/1ps
`include "seeprom_consts.vh"

module seeprom_engine
#(
    parameter                 ADDR_BITS   = `SEEPROM_ADDR_BITS,
    parameter                 WR_CYCLES   = `SEEPROM_WR_CYCLES,
    parameter [127:0]         SERIAL_NUM  = 128'h0123456789ABCDEFFEDCBA9876543210
)
(
    input  wire               core_clk,
    input  wire               rst,
    input  wire               scl_in,
    input  wire               sda_in,
    output wire               sda_out,
    output reg                sda_oe_ff,
    input  wire               write_protect_input,
    input  wire               chip_select_bit_2,
    input  wire               chip_select_bit_1,
    input  wire               chip_select_bit_0,
    output reg                write_busy_ff
);

localparam [2:0] ST_IDLE = 3'h0;
localparam [2:0] ST_DEV  = 3'h1;
localparam [2:0] ST_WADR = 3'h2;
localparam [2:0] ST_WDAT = 3'h3;
localparam [2:0] ST_ACK  = 3'h4;
localparam [2:0] ST_RD   = 3'h5;
localparam [2:0] ST_RACK = 3'h6;

localparam [7:0]  ADDR_MASK = 8'hFF >> (8 - ADDR_BITS);
localparam integer WR_LAST_I = WR_CYCLES - 1;
localparam [23:0] WR_LAST   = WR_LAST_I[23:0];
localparam        DEPTH     = 1 << ADDR_BITS;

// two-stage synchronisers for pins
reg  [2:0]  meta_ff;
reg  [2:0]  sync_ff;
reg         scl_d_ff;
reg         sda_d_ff;
reg  [2:0]  cs_meta_ff;
reg  [2:0]  cs_sync_ff;

// protocol state
reg  [2:0]  state_ff;
reg  [2:0]  after_ack_ff;
reg  [3:0]  bit_cnt_ff;
reg  [7:0]  shift_ff;
reg  [7:0]  tx_ff;
reg  [7:0]  ptr_ff;
reg         serial_ff;
reg         master_ack_ff;

// page buffer and programming
reg  [7:0]  page_ff [0:`SEEPROM_PAGE_BYTES-1];
reg  [7:0]  page_vld_ff;
reg  [7:0]  page_row_ff;
reg         page_pend_ff;
reg  [23:0] wr_cnt_ff;
reg  [7:0]  mem [0:DEPTH-1];

wire        scl_s     = sync_ff[0];
wire        sda_s     = sync_ff[1];
wire        wp_s      = sync_ff[2];
wire        scl_rise  = scl_s & ~scl_d_ff;
wire        scl_fall  = ~scl_s & scl_d_ff;
wire        start_det = scl_s & scl_d_ff & sda_d_ff & ~sda_s;
wire        stop_det  = scl_s & scl_d_ff & ~sda_d_ff & sda_s;
wire [2:0]  cs_pins   = cs_sync_ff; // strap pins, synchronised like the bus pins
wire [3:0]  dev_type  = shift_ff[`SEEPROM_TYPE_HI:`SEEPROM_TYPE_LO];
wire        cs_match  = shift_ff[`SEEPROM_CS_HI:`SEEPROM_CS_LO] == cs_pins;
wire        is_array  = dev_type == `SEEPROM_TYPE_ARRAY;
wire        is_serial = dev_type == `SEEPROM_TYPE_SERIAL;
wire        dev_hit   = cs_match & (is_array | is_serial);
wire        dir_read  = shift_ff[`SEEPROM_DIR_BIT];

// serial byte 0 is the most significant byte; only pointer bits 3:0 pick the byte, bits 7:4 are ignored
wire [127:0] sn_shift = SERIAL_NUM >> {4'hF - ptr_ff[3:0], 3'h0};
wire [7:0]   rd_byte  = serial_ff ? sn_shift[7:0] : mem[ptr_ff & ADDR_MASK];
// array pointer wraps over the whole array, serial pointer over 16 bytes
wire [7:0]   ptr_inc  = serial_ff ? {ptr_ff[7:4], ptr_ff[3:0] + 4'h1}
                                  : ((ptr_ff + 8'h01) & ADDR_MASK);

// the open-drain line is only ever pulled low
assign sda_out = 1'b0;

// pin synchronisers; first stage feeds only the second
always @(posedge core_clk)
begin
    if (rst)
    begin
        meta_ff  <= 3'h7;
        sync_ff  <= 3'h7;
        scl_d_ff <= 1'b1;
        sda_d_ff <= 1'b1;
        cs_meta_ff <= 3'h0;
        cs_sync_ff <= 3'h0;
    end
    else
    begin
        meta_ff  <= {write_protect_input, sda_in, scl_in};
        sync_ff  <= meta_ff;
        cs_meta_ff <= {chip_select_bit_2, chip_select_bit_1, chip_select_bit_0};
        cs_sync_ff <= cs_meta_ff;
        scl_d_ff <= sync_ff[0];
        sda_d_ff <= sync_ff[1];
    end
end

// programming timer and commit of the page buffer into the array
always @(posedge core_clk)
begin : prog_blk
    integer i;
    if (rst)
    begin
        write_busy_ff <= 1'b0;
        wr_cnt_ff     <= 24'h000000;
    end
    else if (write_busy_ff)
    begin
        // timed cycle; protect pin no longer looked at
        if (wr_cnt_ff == WR_LAST)
            write_busy_ff <= 1'b0;
        wr_cnt_ff <= wr_cnt_ff + 24'h000001;
    end
    else if (stop_det && page_pend_ff && !wp_s)
    begin
        write_busy_ff <= 1'b1;
        wr_cnt_ff     <= 24'h000000;
        for (i = 0; i < `SEEPROM_PAGE_BYTES; i = i + 1)
        begin
            // only bytes received are written, all in one row
            if (page_vld_ff[i])
                mem[{page_row_ff[7:3], i[2:0]} & ADDR_MASK] <= page_ff[i];
        end
    end
end

// two-wire protocol engine
always @(posedge core_clk)
begin
    if (rst)
    begin
        state_ff      <= `SEEPROM_STATE_RST;
        after_ack_ff  <= ST_IDLE;
        bit_cnt_ff    <= 4'h0;
        shift_ff      <= 8'h00;
        tx_ff         <= 8'h00;
        ptr_ff        <= `SEEPROM_PTR_RST;
        serial_ff     <= 1'b0;
        master_ack_ff <= 1'b0;
        sda_oe_ff     <= 1'b0;
        page_vld_ff   <= 8'h00;
        page_row_ff   <= 8'h00;
        page_pend_ff  <= 1'b0;
    end
    else if (write_busy_ff)
    begin
        // all bus activity ignored, so write address polls get no ack
        state_ff     <= ST_IDLE;
        sda_oe_ff    <= 1'b0;
        page_pend_ff <= 1'b0;
        page_vld_ff  <= 8'h00;
    end
    else if (start_det)
    begin
        // a repeated start drops an unfinished page (dummy write)
        state_ff     <= ST_DEV;
        bit_cnt_ff   <= 4'h0;
        sda_oe_ff    <= 1'b0;
        page_pend_ff <= 1'b0;
        page_vld_ff  <= 8'h00;
    end
    else if (stop_det)
    begin
        // protected or committed, the buffer is free again at once
        state_ff     <= ST_IDLE;
        sda_oe_ff    <= 1'b0;
        page_pend_ff <= 1'b0;
        page_vld_ff  <= 8'h00;
    end
    else
    begin
        case (state_ff)
            ST_DEV, ST_WADR, ST_WDAT:
            begin
                if (scl_rise && bit_cnt_ff != 4'h8)
                begin
                    shift_ff   <= {shift_ff[6:0], sda_s};
                    bit_cnt_ff <= bit_cnt_ff + 4'h1;
                end
                else if (scl_fall && bit_cnt_ff == 4'h8)
                begin
                    bit_cnt_ff <= 4'h0;
                    if (state_ff == ST_DEV)
                    begin
                        if (dev_hit)
                        begin
                            sda_oe_ff    <= 1'b1;
                            serial_ff    <= is_serial;
                            state_ff     <= ST_ACK;
                            after_ack_ff <= dir_read ? ST_RD : ST_WADR;
                        end
                        else
                            state_ff <= ST_IDLE;
                    end
                    else if (state_ff == ST_WADR)
                    begin
                        // word address width depends on array size
                        ptr_ff       <= serial_ff ? shift_ff : (shift_ff & ADDR_MASK);
                        sda_oe_ff    <= 1'b1;
                        state_ff     <= ST_ACK;
                        after_ack_ff <= ST_WDAT;
                    end
                    else
                    begin
                        // serial region is read-only: acked, never queued
                        if (!serial_ff)
                        begin
                            page_ff[ptr_ff[2:0]]     <= shift_ff;
                            page_vld_ff[ptr_ff[2:0]] <= 1'b1;
                            page_row_ff              <= ptr_ff;
                            page_pend_ff             <= 1'b1;
                        end
                        ptr_ff       <= {ptr_ff[7:3], ptr_ff[2:0] + 3'h1};
                        sda_oe_ff    <= 1'b1;
                        state_ff     <= ST_ACK;
                        after_ack_ff <= ST_WDAT;
                    end
                end
            end
            ST_ACK:
            begin
                if (scl_fall)
                begin
                    if (after_ack_ff == ST_RD)
                    begin
                        // first bit goes out on the same falling edge
                        tx_ff      <= {rd_byte[6:0], 1'b0};
                        sda_oe_ff  <= ~rd_byte[7];
                        ptr_ff     <= ptr_inc;
                        bit_cnt_ff <= 4'h1;
                    end
                    else
                    begin
                        sda_oe_ff  <= 1'b0;
                        bit_cnt_ff <= 4'h0;
                    end
                    state_ff <= after_ack_ff;
                end
            end
            ST_RD:
            begin
                if (scl_fall)
                begin
                    if (bit_cnt_ff == 4'h8)
                    begin
                        // release for the master's ninth-clock answer
                        sda_oe_ff <= 1'b0;
                        state_ff  <= ST_RACK;
                    end
                    else
                    begin
                        sda_oe_ff  <= ~tx_ff[7];
                        tx_ff      <= {tx_ff[6:0], 1'b0};
                        bit_cnt_ff <= bit_cnt_ff + 4'h1;
                    end
                end
            end
            ST_RACK:
            begin
                if (scl_rise)
                    master_ack_ff <= ~sda_s;
                else if (scl_fall)
                begin
                    if (master_ack_ff)
                    begin
                        tx_ff      <= {rd_byte[6:0], 1'b0};
                        sda_oe_ff  <= ~rd_byte[7];
                        ptr_ff     <= ptr_inc;
                        bit_cnt_ff <= 4'h1;
                        state_ff   <= ST_RD;
                    end
                    else
                        state_ff <= ST_IDLE;
                end
            end
            ST_IDLE:
                sda_oe_ff <= 1'b0;
            default:
            begin
                state_ff  <= ST_IDLE;
                sda_oe_ff <= 1'b0;
            end
        endcase
    end
end

endmodule

// >>> verilog/seeprom_consts.vh
// constants for the serial eeprom read/write engine
`ifndef SEEPROM_CONSTS_VH
`define SEEPROM_CONSTS_VH

// device address byte fields
`define SEEPROM_TYPE_ARRAY      4'hA
`define SEEPROM_TYPE_SERIAL     4'hB
`define SEEPROM_TYPE_HI         7
`define SEEPROM_TYPE_LO         4
`define SEEPROM_CS_HI           3
`define SEEPROM_CS_LO           1
`define SEEPROM_DIR_BIT         0

// memory organisation
`define SEEPROM_ADDR_BITS       8
`define SEEPROM_PAGE_BYTES      8
`define SEEPROM_SERIAL_PREFIX   2'h2

// timing: write cycle time in ns and clock period in ns
`define SEEPROM_WR_TIME_NS      5000000
`define SEEPROM_CLK_PERIOD_NS   4
`define SEEPROM_WR_CYCLES       (`SEEPROM_WR_TIME_NS / `SEEPROM_CLK_PERIOD_NS)

// reset values
`define SEEPROM_PTR_RST         8'h00
`define SEEPROM_STATE_RST       3'h0

`endif

// >>> dv/sere_engine_properties.sv
// concurrent checks on the ports of the serial eeprom engine
`timescale 1ns/1ps
module sere_checker
#(
    parameter WR_CYCLES = 50
)
(
    input  wire core_clk,
    input  wire rst,
    input  wire scl_in,
    input  wire sda_in,
    input  wire sda_out,
    input  wire sda_oe_ff,
    input  wire write_protect_input,
    input  wire chip_select_bit_2,
    input  wire chip_select_bit_1,
    input  wire chip_select_bit_0,
    input  wire write_busy_ff
);
    reg [31:0] busy_cnt_ff;
    default clocking cb @(posedge core_clk); endclocking
    default disable iff (rst);
    // length of the running programming cycle, cleared whenever idle
    always @(posedge core_clk)
    begin
        if (rst || !write_busy_ff)
            busy_cnt_ff <= 32'h0;
        else
            busy_cnt_ff <= busy_cnt_ff + 32'h1;
    end
    a_busy_quiet: assert property (write_busy_ff |-> !sda_oe_ff)
        else $error("acknowledge driven during programming");
    a_busy_length: assert property ($fell(write_busy_ff) && !$past(rst) |-> busy_cnt_ff == WR_CYCLES)
        else $error("programming cycle length wrong");
    a_busy_bound: assert property (write_busy_ff |-> busy_cnt_ff < WR_CYCLES)
        else $error("programming cycle overruns");
    a_busy_min_run: assert property ($rose(write_busy_ff) |=> write_busy_ff [*8])
        else $error("programming cycle ends early");
    a_busy_at_stop: assert property ($rose(write_busy_ff) |-> scl_in && sda_in)
        else $error("programming not started by a stop");
    a_wp_blocks: assert property ($rose(write_busy_ff) |-> !$past(write_protect_input, 3))
        else $error("programming while protected");
    a_oe_scl_high: assert property (scl_in && $past(scl_in) && !$past(rst) |-> $stable(sda_oe_ff))
        else $error("data pin changed while clock high");
    a_out_low: assert property (sda_out == 1'b0)
        else $error("open drain output not low");
    c_busy: cover property ($fell(write_busy_ff));
    c_ack: cover property ($rose(sda_oe_ff));
    c_wp: cover property (write_protect_input && sda_oe_ff);
endmodule
bind seeprom_engine sere_checker #(.WR_CYCLES(WR_CYCLES)) i_chk (.core_clk(core_clk), .rst(rst),
    .scl_in(scl_in), .sda_in(sda_in), .sda_out(sda_out), .sda_oe_ff(sda_oe_ff),
    .write_protect_input(write_protect_input), .chip_select_bit_2(chip_select_bit_2),
    .chip_select_bit_1(chip_select_bit_1), .chip_select_bit_0(chip_select_bit_0),
    .write_busy_ff(write_busy_ff));

// >>> dv/sere_master.sv
// two-wire bus master model: drives the clock and pulls the data line low
`timescale 1ns/1ps
module sere_master
(
    input  wire core_clk,
    input  wire sda,
    output reg  scl,
    output reg  sda_low
);
    // idle bus: clock stands high, data released to the pull-up
    initial
    begin
        scl = 1'b1;
        sda_low = 1'b0;
    end
    // wait whole core clocks, then step just off the edge
    task tk(input integer n);
    begin
        repeat (n) @(posedge core_clk);
        #1;
    end
    endtask
    // one bit: data set only while the clock is low, sampled mid-high
    task bit_io(input b, output s);
    begin
        tk(3);
        sda_low = !b;
        tk(3);
        scl = 1'b1;
        tk(3);
        s = sda;
        tk(3);
        scl = 1'b0;
    end
    endtask
    // start or repeated start, leaves the clock low
    task start;
    begin
        sda_low = 1'b0;
        tk(3);
        scl = 1'b1;
        tk(6);
        sda_low = 1'b1;
        tk(6);
        scl = 1'b0;
    end
    endtask
    task stop;
    begin
        tk(3);
        sda_low = 1'b1;
        tk(3);
        scl = 1'b1;
        tk(6);
        sda_low = 1'b0;
        tk(6);
    end
    endtask
    // byte out msb first, data released in the ninth clock for the ack
    task tx(input [7:0] d, output ack);
        integer i;
        reg     s;
    begin
        for (i = 7; i >= 0; i = i - 1)
            bit_io(d[i], s);
        bit_io(1'b1, s);
        ack = !s;
    end
    endtask
    // byte in, then ack or no-ack in the ninth clock
    task rx(input nack, output [7:0] d);
        integer i;
        reg     s;
    begin
        for (i = 7; i >= 0; i = i - 1)
            bit_io(1'b1, d[i]);
        bit_io(nack, s);
    end
    endtask
endmodule

// >>> dv/testbench.sv
// self-checking testbench for the serial eeprom engine
`timescale 1ns/1ps
module testbench;
    localparam         WRC = 50;
    localparam [127:0] SN  = 128'h0F1E2D3C4B5A69788796A5B4C3D2E1F0; // arbitrary value
    reg        core_clk;
    reg        rst;
    reg        wp;
    reg        a;
    reg  [7:0] d;
    reg  [2:0] cs;
    reg  [7:0] got [0:16];
    wire       scl;
    wire       m_low;
    wire       oe;
    wire       sda_out;
    wire       busy;
    wire       sda;
    integer    bad_count;
    integer    num_checks;
    integer    i;
    // wired-and data line with pull-up
    assign sda = (oe ? sda_out : 1'b1) & ~m_low;
    seeprom_engine #(.ADDR_BITS(8), .WR_CYCLES(WRC), .SERIAL_NUM(SN)) i_dut (.core_clk(core_clk), .rst(rst),
        .scl_in(scl), .sda_in(sda), .sda_out(sda_out), .sda_oe_ff(oe), .write_protect_input(wp),
        .chip_select_bit_2(cs[2]), .chip_select_bit_1(cs[1]), .chip_select_bit_0(cs[0]), .write_busy_ff(busy));
    sere_master i_mst (.core_clk(core_clk), .sda(sda), .scl(scl), .sda_low(m_low));
    // 4 ns core clock
    initial
    begin
        core_clk = 1'b0;
        forever #2 core_clk = ~core_clk;
    end
    task chk(input [7:0] s, input [7:0] e);
    begin
        num_checks = num_checks + 1;
        if (s !== e)
        begin
            bad_count = bad_count + 1;
            $display("ERROR %0t: saw %h expected %h", $time, s, e);
        end
    end
    endtask
    task close_out;
    begin
        $display("checks %0d mismatches %0d", num_checks, bad_count);
        if (bad_count == 0 && num_checks > 0)
            $display("All tests passed");
        else
            $display("Some tests failed");
        $finish;
    end
    endtask
    // bounded wait for the programming cycle to finish
    task wait_idle;
        integer n;
    begin
        n = 0;
        while (busy !== 1'b0 && n < 4 * WRC)
        begin
            i_mst.tk(1);
            n = n + 1;
        end
        if (busy !== 1'b0)
        begin
            bad_count = bad_count + 1;
            close_out;
        end
    end
    endtask
    task hdr(input [7:0] dv, input [7:0] ad);
    begin
        i_mst.start;
        i_mst.tx(dv, a);
        chk(a, 8'h01);
        i_mst.tx(ad, a);
        chk(a, 8'h01);
    end
    endtask
    // write n bytes base, base+1, ... from ad, ending with a stop
    task wr(input [7:0] ad, input [7:0] base, input integer n);
    begin
        hdr(8'hAA, ad);
        for (i = 0; i < n; i = i + 1)
        begin
            i_mst.tx(base + i[7:0], a);
            chk(a, 8'h01);
        end
        i_mst.stop;
    end
    endtask
    // dummy write, repeated start, n bytes read, no-ack on the last
    task rd(input [7:0] dv, input [7:0] ad, input integer n);
    begin
        hdr(dv, ad);
        i_mst.start;
        i_mst.tx(dv | 8'h01, a);
        chk(a, 8'h01);
        for (i = 0; i < n; i = i + 1)
            i_mst.rx(i == n - 1, got[i]);
        i_mst.stop;
    end
    endtask
    task t_byte_poll;
    begin
        wr(8'h3C, 8'h5A, 1);
        chk(busy, 8'h01);
        wp = 1'b1;
        i_mst.start;
        i_mst.tx(8'hAA, a);
        chk(a, 8'h00);
        i_mst.stop;
        wait_idle;
        wp = 1'b0;
        i_mst.start;
        i_mst.tx(8'hAA, a);
        chk(a, 8'h01);
        i_mst.stop;
        rd(8'hAA, 8'h3C, 1);
        chk(got[0], 8'h5A);
        $display("test byte_poll done");
    end
    endtask
    task t_page;
    begin
        wr(8'h45, 8'h10, 8);
        wait_idle;
        rd(8'hAA, 8'h40, 8);
        for (i = 0; i < 8; i = i + 1)
            chk(got[i], 8'h10 + 8'((i + 3) % 8));
        wr(8'h41, 8'h60, 2);
        wait_idle;
        rd(8'hAA, 8'h40, 4);
        chk(got[0], 8'h13);
        chk(got[1], 8'h60);
        chk(got[2], 8'h61);
        chk(got[3], 8'h16);
        $display("test page done");
    end
    endtask
    task t_protect;
    begin
        wp = 1'b1;
        wr(8'h41, 8'h77, 1);
        chk(busy, 8'h00);
        wp = 1'b0;
        rd(8'hAA, 8'h41, 1);
        chk(got[0], 8'h60);
        $display("test protect done");
    end
    endtask
    task t_wrap;
    begin
        wr(8'hFF, 8'h11, 1);
        wait_idle;
        wr(8'h00, 8'h22, 1);
        wait_idle;
        rd(8'hAA, 8'hFF, 1);
        chk(got[0], 8'h11);
        i_mst.start;
        i_mst.tx(8'hAB, a);
        chk(a, 8'h01);
        i_mst.rx(1'b1, d);
        i_mst.stop;
        chk(d, 8'h22);
        $display("test wrap done");
    end
    endtask
    task t_serial;
    begin
        rd(8'hBA, 8'h80, 17);
        for (i = 0; i < 17; i = i + 1)
            chk(got[i], SN[127 - 8 * (i % 16) -: 8]);
        $display("test serial done");
    end
    endtask
    task t_nomatch;
    begin
        i_mst.start;
        i_mst.tx(8'hA0, a);
        chk(a, 8'h00);
        i_mst.stop;
        i_mst.start;
        i_mst.tx(8'h9B, a);
        chk(a, 8'h00);
        i_mst.stop;
        // strap levels moved: the old address goes dead, the new one answers
        cs = 3'h0;
        i_mst.start;
        i_mst.tx(8'hA0, a);
        chk(a, 8'h01);
        i_mst.stop;
        i_mst.start;
        i_mst.tx(8'hAA, a);
        chk(a, 8'h00);
        i_mst.stop;
        cs = 3'h5;
        $display("test nomatch done");
    end
    endtask
    // reset, then the scenarios in turn
    initial
    begin
        rst = 1'b1;
        wp = 1'b0;
        cs = 3'h5;
        bad_count = 0;
        num_checks = 0;
        repeat (6) @(posedge core_clk);
        #1;
        rst = 1'b0;
        i_mst.tk(6);
        t_byte_poll;
        t_page;
        t_protect;
        t_wrap;
        t_serial;
        t_nomatch;
        close_out;
    end
endmodule
